// file: verilog/tpc_probe_capture.v
// dual touch-probe position capture with input monitor word
// assumes synchronous inputs and a master that issues one access at a time
`timescale 1ns/10ps
`include "tpc_defs.vh"

module tpc_probe_capture (
	input  wire        clk,
	input  wire        rst_n,
	input  wire [31:0] motorPosition,
	input  wire [5:0]  isolatedInputs,
	input  wire        odWrite,
	input  wire        odRead,
	input  wire [15:0] odIndex,
	input  wire [31:0] odWriteData,
	output wire [31:0] odReadData,
	output reg         odAck,
	output reg         odError,
	output wire        clockwiseEndStop,
	output wire        counterclockwiseEndStop,
	output wire        referenceSwitch
);
	reg  [15:0] settings;
	reg  [31:0] inputFunction;
	reg  [31:0] inputPolarity;
	reg         oneRiseSeen;
	reg         oneFallSeen;
	reg         twoRiseSeen;
	reg         twoFallSeen;
	reg         oneLevelPrev;
	reg         twoLevelPrev;
	reg  [31:0] regReadData;
	reg         readFromMem;
	reg  [1:0]  memReadAddr;
	wire [31:0] memReadData;
	wire [5:0]  validInputs;
	wire        oneLevel;
	wire        twoLevel;
	wire        oneEn;
	wire        twoEn;
	wire        oneRiseEvt;
	wire        oneFallEvt;
	wire        twoRiseEvt;
	wire        twoFallEvt;
	wire        setWrite;
	wire        oneRearm;
	wire        twoRearm;
	wire [15:0] statusWord;
	wire [31:0] monitorWord;
	wire [31:0] maskedSettings;
	wire [15:0] captureOffset;

	// picks one of the six valid inputs by a 3-bit field; codes 6 and 7 read inactive
	function pick_input;
		input [5:0] levels;
		input [2:0] sel;
		begin
			if (sel < 3'h6) begin
				pick_input = levels[sel];
			end else begin
				pick_input = 1'b0;
			end
		end
	endfunction

	// true when the index names one of the four captured-position words
	function is_capture_index;
		input [15:0] index;
		begin
			is_capture_index = (index >= `TPC_IDX_ONE_RISING) &&
				(index <= `TPC_IDX_TWO_FALLING);
		end
	endfunction

	// only settings, function and polarity words take writes
	function is_writable_index;
		input [15:0] index;
		begin
			is_writable_index = (index == `TPC_IDX_SETTINGS) ||
				(index == `TPC_IDX_INPUT_FUNC) ||
				(index == `TPC_IDX_INPUT_POL);
		end
	endfunction

	// an edge counts only while the probe is armed and that edge is enabled
	function edge_event;
		input armed;
		input edgeOn;
		input level;
		input levelPrev;
		input rising;
		begin
			if (rising) begin
				edge_event = armed && edgeOn && level && !levelPrev;
			end else begin
				edge_event = armed && edgeOn && !level && levelPrev;
			end
		end
	endfunction

	// turning on, keeping on or turning off all count as re-arm
	function rearm_event;
		input isWrite;
		input newEn;
		input oldEn;
		begin
			rearm_event = isWrite && (newEn != oldEn || newEn);
		end
	endfunction

	// polarity bit 1 inverts the pin, so 1 always means valid
	assign validInputs = isolatedInputs ^ inputPolarity[5:0];

	// function assignment routes inputs to probes, limits and home
	assign oneLevel = pick_input(validInputs,
		inputFunction[`TPC_FUNC_ONE_LSB +: 3]);
	assign twoLevel = pick_input(validInputs,
		inputFunction[`TPC_FUNC_TWO_LSB +: 3]);
	assign clockwiseEndStop = pick_input(validInputs,
		inputFunction[`TPC_FUNC_CW_LSB +: 3]);
	assign counterclockwiseEndStop = pick_input(validInputs,
		inputFunction[`TPC_FUNC_CCW_LSB +: 3]);
	assign referenceSwitch = pick_input(validInputs,
		inputFunction[`TPC_FUNC_HOME_LSB +: 3]);

	assign oneEn = settings[`TPC_SET_ONE_EN];
	assign twoEn = settings[`TPC_SET_TWO_EN];

	// edges are taken only while the probe is armed and that edge is enabled
	assign oneRiseEvt = edge_event(oneEn, settings[`TPC_SET_ONE_RISE],
		oneLevel, oneLevelPrev, 1'b1);
	assign oneFallEvt = edge_event(oneEn, settings[`TPC_SET_ONE_FALL],
		oneLevel, oneLevelPrev, 1'b0);
	assign twoRiseEvt = edge_event(twoEn, settings[`TPC_SET_TWO_RISE],
		twoLevel, twoLevelPrev, 1'b1);
	assign twoFallEvt = edge_event(twoEn, settings[`TPC_SET_TWO_FALL],
		twoLevel, twoLevelPrev, 1'b0);

	// a combined read and write is refused, so it must not re-arm either
	assign setWrite = odWrite && !odRead && (odIndex == `TPC_IDX_SETTINGS);
	assign maskedSettings = odWriteData & {16'h0000, `TPC_SET_MASK};

	// a write that turns or keeps the enable on, or one that turns it off, clears the flags
	assign oneRearm = rearm_event(setWrite,
		maskedSettings[`TPC_SET_ONE_EN], oneEn);
	assign twoRearm = rearm_event(setWrite,
		maskedSettings[`TPC_SET_TWO_EN], twoEn);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oneLevelPrev <= 1'b0;
			twoLevelPrev <= 1'b0;
		end else begin
			oneLevelPrev <= oneLevel;
			twoLevelPrev <= twoLevel;
		end
	end

	// sticky flags: a capture in the clearing cycle wins over the clear
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oneRiseSeen <= 1'b0;
			oneFallSeen <= 1'b0;
			twoRiseSeen <= 1'b0;
			twoFallSeen <= 1'b0;
		end else begin
			if (oneRiseEvt) begin
				oneRiseSeen <= 1'b1;
			end else if (oneRearm || !oneEn) begin
				oneRiseSeen <= 1'b0;
			end
			if (oneFallEvt) begin
				oneFallSeen <= 1'b1;
			end else if (oneRearm || !oneEn) begin
				oneFallSeen <= 1'b0;
			end
			if (twoRiseEvt) begin
				twoRiseSeen <= 1'b1;
			end else if (twoRearm || !twoEn) begin
				twoRiseSeen <= 1'b0;
			end
			if (twoFallEvt) begin
				twoFallSeen <= 1'b1;
			end else if (twoRearm || !twoEn) begin
				twoFallSeen <= 1'b0;
			end
		end
	end

	// one input cannot rise and fall in one cycle, so each port writes one word
	tpc_capture_mem u_capture_mem (
		.clk          (clk),
		.rst_n        (rst_n),
		.writeOneEn   (oneRiseEvt || oneFallEvt),
		.writeOneAddr (oneRiseEvt ? `TPC_MEM_ONE_RISING : `TPC_MEM_ONE_FALLING),
		.writeOneData (motorPosition),
		.writeTwoEn   (twoRiseEvt || twoFallEvt),
		.writeTwoAddr (twoRiseEvt ? `TPC_MEM_TWO_RISING : `TPC_MEM_TWO_FALLING),
		.writeTwoData (motorPosition),
		.readAddr     (memReadAddr),
		.readData     (memReadData)
	);

	// capture indices are consecutive, so the low bits give the word address
	assign captureOffset = odIndex - `TPC_IDX_ONE_RISING;

	always @* begin
		memReadAddr = captureOffset[1:0];
	end

	assign statusWord = {5'h00, twoFallSeen, twoRiseSeen, twoEn,
		5'h00, oneFallSeen, oneRiseSeen, oneEn};
	assign monitorWord = {10'h000, validInputs, 13'h0000,
		referenceSwitch, counterclockwiseEndStop, clockwiseEndStop};

	// writable words; read-only indices refuse writes with odError
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			settings      <= `TPC_SET_RESET;
			inputFunction <= `TPC_FUNC_RESET;
			inputPolarity <= `TPC_POL_RESET;
		end else if (odWrite && !odRead) begin
			if (odIndex == `TPC_IDX_SETTINGS) begin
				settings <= maskedSettings[15:0];
			end else if (odIndex == `TPC_IDX_INPUT_FUNC) begin
				inputFunction <= odWriteData & `TPC_FUNC_MASK;
			end else if (odIndex == `TPC_IDX_INPUT_POL) begin
				inputPolarity <= odWriteData & `TPC_POL_MASK;
			end
		end
	end

	// answer one cycle after the request; both read sources are flip-flops
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			odAck       <= 1'b0;
			odError     <= 1'b0;
			regReadData <= 32'h0000_0000;
			readFromMem <= 1'b0;
		end else begin
			odAck       <= odWrite || odRead;
			odError     <= 1'b0;
			readFromMem <= 1'b0;
			// the store's output follows the index, so keep the answered word here
			if (readFromMem) begin
				regReadData <= memReadData;
			end
			if (odWrite && odRead) begin
				odError <= 1'b1;
			end else if (odWrite) begin
				if (!is_writable_index(odIndex)) begin
					odError <= 1'b1;
				end
			end else if (odRead) begin
				if (odIndex == `TPC_IDX_SETTINGS) begin
					regReadData <= {16'h0000, settings};
				end else if (odIndex == `TPC_IDX_STATUS) begin
					regReadData <= {16'h0000, statusWord};
				end else if (is_capture_index(odIndex)) begin
					readFromMem <= 1'b1;
				end else if (odIndex == `TPC_IDX_PIN_MONITOR) begin
					regReadData <= monitorWord;
				end else if (odIndex == `TPC_IDX_INPUT_FUNC) begin
					regReadData <= inputFunction;
				end else if (odIndex == `TPC_IDX_INPUT_POL) begin
					regReadData <= inputPolarity;
				end else begin
					regReadData <= 32'h0000_0000;
					odError     <= 1'b1;
				end
			end
		end
	end

	assign odReadData = readFromMem ? memReadData : regReadData;
endmodule // tpc_probe_capture

// file: verilog/tpc_defs.vh
// constants for the dual touch-probe position capture unit
// assumes object-dictionary indices arrive as 16-bit numbers, data as 32-bit words
`ifndef TPC_DEFS_VH
`define TPC_DEFS_VH

// object-dictionary indices
`define TPC_IDX_SETTINGS      16'h60b8
`define TPC_IDX_STATUS        16'h60b9
`define TPC_IDX_ONE_RISING    16'h60ba
`define TPC_IDX_ONE_FALLING   16'h60bb
`define TPC_IDX_TWO_RISING    16'h60bc
`define TPC_IDX_TWO_FALLING   16'h60bd
`define TPC_IDX_PIN_MONITOR   16'h60fd
`define TPC_IDX_INPUT_FUNC    16'h2007
`define TPC_IDX_INPUT_POL     16'h2008

// settings word fields
`define TPC_SET_ONE_EN        0
`define TPC_SET_ONE_RISE      4
`define TPC_SET_ONE_FALL      5
`define TPC_SET_TWO_EN        8
`define TPC_SET_TWO_RISE      12
`define TPC_SET_TWO_FALL      13
`define TPC_SET_MASK          16'h3131
`define TPC_SET_RESET         16'h0000

// status word fields
`define TPC_STA_ONE_EN        0
`define TPC_STA_ONE_RISE      1
`define TPC_STA_ONE_FALL      2
`define TPC_STA_TWO_EN        8
`define TPC_STA_TWO_RISE      9
`define TPC_STA_TWO_FALL      10

// input monitor word fields
`define TPC_MON_CW            0
`define TPC_MON_CCW           1
`define TPC_MON_HOME          2
`define TPC_MON_IN_LSB        16
`define TPC_MON_IN_MSB        21

// input function word: 3-bit source selects, one per function
`define TPC_FUNC_ONE_LSB      0
`define TPC_FUNC_TWO_LSB      4
`define TPC_FUNC_CW_LSB       8
`define TPC_FUNC_CCW_LSB      12
`define TPC_FUNC_HOME_LSB     16
`define TPC_FUNC_MASK         32'h0007_7777
`define TPC_FUNC_RESET        32'h0004_3210
`define TPC_POL_MASK          32'h0000_003f
`define TPC_POL_RESET         32'h0000_0000

// capture memory word addresses
`define TPC_MEM_ONE_RISING    2'h0
`define TPC_MEM_ONE_FALLING   2'h1
`define TPC_MEM_TWO_RISING    2'h2
`define TPC_MEM_TWO_FALLING   2'h3

`endif

// file: verilog/tpc_capture_mem.v
// four-word store for captured positions, two write ports, one registered read
// assumes the two write ports never address the same word in one cycle
`timescale 1ns/10ps

module tpc_capture_mem (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        writeOneEn,
	input  wire [1:0]  writeOneAddr,
	input  wire [31:0] writeOneData,
	input  wire        writeTwoEn,
	input  wire [1:0]  writeTwoAddr,
	input  wire [31:0] writeTwoData,
	input  wire [1:0]  readAddr,
	output reg  [31:0] readData
);
	reg [31:0] word [0:3];
	integer    i;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < 4; i = i + 1) begin
				word[i] <= 32'h0000_0000;
			end
			readData <= 32'h0000_0000;
		end else begin
			if (writeOneEn) begin
				word[writeOneAddr] <= writeOneData;
			end
			if (writeTwoEn) begin
				word[writeTwoAddr] <= writeTwoData;
			end
			// old contents on a same-cycle write; a fresh capture shows one read later
			readData <= word[readAddr];
		end
	end
endmodule // tpc_capture_mem

// file: tb/tpc_checker.sv
// assertions on the object access port of the probe capture unit
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/10ps

module tpc_checker (
	input wire        clk,
	input wire        rst_n,
	input wire        odWrite,
	input wire        odRead,
	input wire [15:0] odIndex,
	input wire [31:0] odWriteData,
	input wire [31:0] odReadData,
	input wire        odAck,
	input wire        odError
);
	wire        req = odWrite || odRead;
	wire        ro = odIndex == 16'h60b9 || odIndex == 16'h60fd ||
		(odIndex >= 16'h60ba && odIndex <= 16'h60bd);
	wire        known = (odIndex >= 16'h60b8 && odIndex <= 16'h60bd) ||
		odIndex == 16'h60fd || odIndex == 16'h2007 || odIndex == 16'h2008;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_arm;
		odWrite && !odRead && odIndex == 16'h60b8 && odWriteData[0] && odWriteData[8];
	endsequence
	sequence s_status_rd;
		odRead && !odWrite && odIndex == 16'h60b9;
	endsequence

	a_ack_after_req: assert property (req |=> odAck)
		else $error("no answer after a request");
	a_ack_has_cause: assert property (odAck |-> $past(req))
		else $error("answer without a request");
	a_data_holds: assert property ($changed(odReadData) |-> $past(odRead))
		else $error("read data moved without a read");
	a_unknown_refused: assert property (odRead && !odWrite && !known |=>
		odError && odReadData == 32'h0) else $error("unknown index not refused");
	a_ro_write_refused: assert property (odWrite && !odRead && ro |=> odError)
		else $error("write to read-only index accepted");
	a_both_refused: assert property (odWrite && odRead |=> odAck && odError)
		else $error("read and write together accepted");
	a_settings_ok: assert property (odWrite && !odRead && odIndex == 16'h60b8 |=>
		!odError) else $error("settings write refused");
	a_status_enables: assert property (s_arm ##3 s_status_rd |=>
		odReadData[0] && odReadData[8]) else $error("enables missing in status");
	a_status_reserved: assert property (odAck &&
		$past(odRead && !odWrite && odIndex == 16'h60b9) |->
		odReadData[31:11] == 21'h0 && odReadData[7:3] == 5'h0)
		else $error("reserved status bits set");
	a_monitor_reserved: assert property (odAck &&
		$past(odRead && !odWrite && odIndex == 16'h60fd) |->
		odReadData[31:22] == 10'h0 && odReadData[15:3] == 13'h0)
		else $error("reserved monitor bits set");
endmodule // tpc_checker

bind tpc_probe_capture tpc_checker tpc_checker_inst (.clk(clk), .rst_n(rst_n),
	.odWrite(odWrite), .odRead(odRead), .odIndex(odIndex), .odWriteData(odWriteData),
	.odReadData(odReadData), .odAck(odAck), .odError(odError));

// file: tb/tpc_master_model.sv
// fieldbus master model issuing object-dictionary accesses
// assumes the answer comes one cycle after the request edge
`timescale 1ns/10ps

module tpc_master_model (
	input  wire        clk,
	input  wire [31:0] odReadData,
	input  wire        odAck,
	input  wire        odError,
	output reg         odWrite,
	output reg         odRead,
	output reg  [15:0] odIndex,
	output reg  [31:0] odWriteData
);
	initial begin
		odWrite = 1'b0;
		odRead = 1'b0;
		odIndex = 16'h0;
		odWriteData = 32'h0;
	end

	task xfer(input w, input r, input [15:0] idx, input [31:0] d,
		output [31:0] q, output e, output a);
		begin
			@(posedge clk);
			odWrite <= w;
			odRead <= r;
			odIndex <= idx;
			odWriteData <= d;
			@(posedge clk);
			odWrite <= 1'b0;
			odRead <= 1'b0;
			// released lines inverted so stale values never look valid
			odIndex <= ~idx;
			odWriteData <= ~d;
			@(posedge clk);
			q = odReadData;
			e = odError;
			a = odAck;
		end
	endtask
endmodule // tpc_master_model

// file: tb/testbench.sv
// self-checking bench for the probe capture unit
// assumes the master model answers every access in fixed time
`timescale 1ns/10ps

module testbench;
	reg         clk;
	reg         rst_n;
	reg  [31:0] motorPosition;
	reg  [5:0]  isolatedInputs;
	wire        odWrite, odRead, odAck, odError, cwStop, ccwStop, homeSw;
	wire [15:0] odIndex;
	wire [31:0] odWriteData, odReadData;
	integer     errors, n_compared, i;
	reg  [31:0] q;
	reg         e, a;

	tpc_probe_capture tpc_probe_capture_inst (.clk(clk), .rst_n(rst_n),
		.motorPosition(motorPosition), .isolatedInputs(isolatedInputs),
		.odWrite(odWrite), .odRead(odRead), .odIndex(odIndex), .odWriteData(odWriteData),
		.odReadData(odReadData), .odAck(odAck), .odError(odError),
		.clockwiseEndStop(cwStop), .counterclockwiseEndStop(ccwStop),
		.referenceSwitch(homeSw));
	tpc_master_model tpc_master_model_inst (.clk(clk), .odReadData(odReadData),
		.odAck(odAck), .odError(odError), .odWrite(odWrite), .odRead(odRead),
		.odIndex(odIndex), .odWriteData(odWriteData));

	task check(input [39:0] got, input [39:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("ERROR %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task xf(input w, input r, input [15:0] idx, input [31:0] d, input [31:0] x, input ee);
		begin
			tpc_master_model_inst.xfer(w, r, idx, d, q, e, a);
			check({6'h0, a, e, r ? q : 32'h0}, {6'h0, 1'b1, ee, x});
		end
	endtask
	task rd(input [15:0] idx, input [31:0] x, input ee);
		xf(1'b0, 1'b1, idx, 32'h0, x, ee);
	endtask
	task wr(input [15:0] idx, input [31:0] d, input ee);
		xf(1'b1, 1'b0, idx, d, 32'h0, ee);
	endtask
	task pin(input [5:0] v, input [31:0] p);
		begin
			@(posedge clk);
			isolatedInputs <= v;
			motorPosition <= p;
			repeat (2) @(posedge clk);
		end
	endtask

	task t_reset;
		begin
			for (i = 0; i < 6; i = i + 1) rd(16'h60b8 + i[15:0], 32'h0, 1'b0);
			rd(16'h60fd, 32'h0, 1'b0);
			wr(16'h60b9, 32'hffff, 1'b1);
			wr(16'h60ba, 32'h1, 1'b1);
			rd(16'h60ba, 32'h0, 1'b0);
			rd(16'h1234, 32'h0, 1'b1);
			wr(16'h60b8, 32'hffff, 1'b0);
			rd(16'h60b8, 32'h3131, 1'b0);
			xf(1'b1, 1'b1, 16'h60b8, 32'h0, 32'h3131, 1'b1);
			rd(16'h60b8, 32'h3131, 1'b0);
			$display("test reset done");
		end
	endtask
	task t_probes;
		begin
			wr(16'h60b8, 32'h0031, 1'b0);
			pin(6'h01, 32'h11111111);
			rd(16'h60b9, 32'h0003, 1'b0);
			pin(6'h00, 32'h22222222);
			rd(16'h60b9, 32'h0007, 1'b0);
			rd(16'h60ba, 32'h11111111, 1'b0);
			rd(16'h60bb, 32'h22222222, 1'b0);
			wr(16'h60b8, 32'h1100, 1'b0);
			pin(6'h03, 32'h33333333);
			pin(6'h00, 32'h44444444);
			rd(16'h60b9, 32'h0300, 1'b0);
			rd(16'h60ba, 32'h11111111, 1'b0);
			rd(16'h60bc, 32'h33333333, 1'b0);
			rd(16'h60bd, 32'h0, 1'b0);
			wr(16'h60b8, 32'h3101, 1'b0);
			rd(16'h60b9, 32'h0101, 1'b0);
			pin(6'h02, 32'h55555555);
			pin(6'h00, 32'h66666666);
			rd(16'h60b9, 32'h0701, 1'b0);
			rd(16'h60bd, 32'h66666666, 1'b0);
			$display("test probes done");
		end
	endtask
	task t_monitor;
		begin
			pin(6'h2a, 32'h0);
			rd(16'h60fd, 32'h002a0002, 1'b0);
			check({cwStop, ccwStop, homeSw}, 3'b010);
			wr(16'h2008, 32'h3f, 1'b0);
			rd(16'h60fd, 32'h00150005, 1'b0);
			wr(16'h2007, 32'h00043110, 1'b0);
			rd(16'h60fd, 32'h00150004, 1'b0);
			wr(16'h2007, 32'h00073110, 1'b0);
			rd(16'h60fd, 32'h00150000, 1'b0);
			$display("test monitor done");
		end
	endtask

	task close_out;
		begin
			$display("compared %0d mismatches %0d", n_compared, errors);
			if (errors == 0 && n_compared > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#50000;
		errors = errors + 1;
		close_out;
	end
	initial begin
		errors = 0;
		n_compared = 0;
		rst_n = 1'b0;
		motorPosition = 32'h0;
		isolatedInputs = 6'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_probes;
		t_monitor;
		close_out;
	end
endmodule // testbench
